// ===== core/rap_lpf.sv
// first-order low-pass filter with a power-of-two coefficient
// assumes i_x is stable in each cycle where i_en is high
`timescale 1ns/1ps
module rap_lpf #(
  parameter int W = 24,
  parameter int K = 8
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_en,
  input wire logic signed [W-1:0] i_x,
  output logic signed [W-1:0] o_y
);

  logic signed [W+K-1:0] acc;
  logic signed [W+K-1:0] next_acc;
  logic signed [W+K:0] diff;
  logic signed [W+K:0] step;

  // ********************************************
  // y += (x - y) / 2^K
  // ********************************************
  always_comb
  begin
    diff = {i_x[W-1], i_x, {K{1'b0}}} - {acc[W+K-1], acc};
    step = diff >>> K;
    next_acc = acc;
    if (i_en)
    begin
      next_acc = acc + step[W+K-1:0];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      acc <= '0;
    end
    else
    begin
      acc <= next_acc;
    end
  end

  assign o_y = acc[W+K-1:K];

endmodule

// ===== core/rap_pkg.sv
// constants shared by the rms and active power block
// assumes one 100 MHz master clock and an 8-bit address register port
package rap_pkg;

  // ********************************************
  // clocking
  // ********************************************
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned MCLK_PERIOD_NS = 10;
  localparam int unsigned UPDATE_DIV = 5;
  localparam logic [2:0] UPDATE_DIV_LAST = 3'(UPDATE_DIV - 1);
  // waveform rate: update rate / 32 at the fastest setting
  localparam int unsigned WAVE_BASE_DIV = 32;
  localparam logic [7:0] WAVE_BASE_LAST = 8'(WAVE_BASE_DIV - 1);

  // ********************************************
  // register port
  // ********************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;

  localparam logic [7:0] OFS_SECOND_MODE_CONFIG = 8'h0c;
  localparam logic [7:0] OFS_WAVEFORM_SOURCE_SELECT = 8'h0d;
  localparam logic [7:0] OFS_ACTIVE_POWER_GAIN = 8'h1d;
  localparam logic [7:0] OFS_CURRENT_RMS_OFFSET = 8'h22;
  localparam logic [7:0] OFS_VOLTAGE_RMS_OFFSET = 8'h23;
  localparam logic [7:0] OFS_VOLTAGE_RMS_LOW_BYTE = 8'hd1;
  localparam logic [7:0] OFS_VOLTAGE_RMS_MID_BYTE = 8'hd2;
  localparam logic [7:0] OFS_VOLTAGE_RMS_HIGH_BYTE = 8'hd3;
  localparam logic [7:0] OFS_CURRENT_RMS_LOW_BYTE = 8'hd4;
  localparam logic [7:0] OFS_CURRENT_RMS_MID_BYTE = 8'hd5;
  localparam logic [7:0] OFS_CURRENT_RMS_HIGH_BYTE = 8'hd6;
  localparam logic [7:0] OFS_METERING_IRQ_ENABLE_UPPER = 8'hdb;

  // ********************************************
  // fields
  // ********************************************
  localparam int RMS_ZERO_CROSS_UPDATE_BIT = 2;
  localparam int WAVEFORM_SAMPLE_IRQ_ENABLE_BIT = 5;
  localparam int WAVE_SRC_LSB = 0;
  localparam int WAVE_SRC_W = 3;
  localparam int WAVE_RATE_LSB = 3;
  localparam int WAVE_RATE_W = 2;

  localparam logic [2:0] WAVE_SRC_CURRENT = 3'h0;
  localparam logic [2:0] WAVE_SRC_VOLTAGE = 3'h1;
  localparam logic [2:0] WAVE_SRC_POWER = 3'h2;
  localparam logic [2:0] WAVE_SRC_CURRENT_RMS = 3'h3;

  // ********************************************
  // reset values
  // ********************************************
  localparam logic [7:0] RST_SECOND_MODE_CONFIG = 8'h00;
  localparam logic [7:0] RST_WAVEFORM_SOURCE_SELECT = 8'h00;
  localparam logic [7:0] RST_METERING_IRQ_ENABLE_UPPER = 8'h00;
  localparam logic [11:0] RST_ACTIVE_POWER_GAIN = 12'h000;
  localparam logic [11:0] RST_CURRENT_RMS_OFFSET = 12'h000;
  localparam logic [11:0] RST_VOLTAGE_RMS_OFFSET = 12'h000;

  // ********************************************
  // arithmetic
  // ********************************************
  localparam int IRMS_OS_SHIFT = 15;
  localparam int VRMS_OS_SHIFT = 6;
  localparam int GAIN_FRAC = 12;
  localparam int SQ_AVG_SHIFT = 16;
  localparam int VMAV_SHIFT = 16;
  localparam int PWR_SHIFT = 14;
  localparam int VRMS_SCALE_W = 9;
  localparam logic [8:0] VRMS_SCALE = 9'h11c;
  localparam int SQRT_STEPS = 25;
  localparam logic [4:0] SQRT_LAST = 5'(SQRT_STEPS - 1);

  typedef enum logic {SQ_IDLE, SQ_RUN} rap_sqrt_e;

endpackage

// ===== core/rms_and_active_power_dsp.sv
// current rms, voltage rms and active power for an energy meter
// assumes samples synchronous to I_MCLK, read each update pulse
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
module rms_and_active_power_dsp #(
  parameter int CUR_W = 24,
  parameter int VOLT_W = 16,
  parameter int GAIN_W = 12
) (
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [rap_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [rap_pkg::DATA_W-1:0] I_WR_DATA,
  input wire logic I_WR_STB,
  input wire logic I_RD_STB,
  input wire logic signed [CUR_W-1:0] I_CUR_SAMPLE,
  input wire logic signed [VOLT_W-1:0] I_VOLT_SAMPLE,
  input wire logic I_VOLT_ZX,
  output logic [rap_pkg::DATA_W-1:0] O_RD_DATA,
  output logic [23:0] O_WAVE_DATA,
  output logic O_WAVE_STB,
  output logic signed [23:0] O_ACTIVE_POWER
);
  import rap_pkg::*;

  localparam int SQ_W = 2 * CUR_W;
  localparam int PW = CUR_W + VOLT_W;
  localparam int GF_W = GAIN_W + 2;
  localparam int VM_W = VOLT_W + 1;

  // ********************************************
  // update divider
  // ********************************************
  logic [2:0] div_cnt;
  logic [2:0] next_div_cnt;
  logic ce;
  logic next_ce;

  always_comb
  begin
    next_ce = (div_cnt == UPDATE_DIV_LAST);
    next_div_cnt = next_ce ? 3'h0 : div_cnt + 3'h1;
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      div_cnt <= 3'h0;
      ce <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      ce <= next_ce;
    end
  end

  // ********************************************
  // control registers
  // ********************************************
  logic [7:0] second_mode_config;
  logic [7:0] waveform_source_select;
  logic [7:0] metering_irq_enable_upper;
  logic [11:0] active_power_gain;
  logic [11:0] current_rms_offset;
  logic [11:0] voltage_rms_offset;
  logic [7:0] next_second_mode_config;
  logic [7:0] next_waveform_source_select;
  logic [7:0] next_metering_irq_enable_upper;
  logic [11:0] next_active_power_gain;
  logic [11:0] next_current_rms_offset;
  logic [11:0] next_voltage_rms_offset;

  always_comb
  begin
    next_second_mode_config = second_mode_config;
    next_waveform_source_select = waveform_source_select;
    next_metering_irq_enable_upper = metering_irq_enable_upper;
    next_active_power_gain = active_power_gain;
    next_current_rms_offset = current_rms_offset;
    next_voltage_rms_offset = voltage_rms_offset;
    if (I_WR_STB)
    begin
      unique case (I_ADDR)
        OFS_SECOND_MODE_CONFIG: next_second_mode_config = I_WR_DATA[7:0];
        OFS_WAVEFORM_SOURCE_SELECT: next_waveform_source_select = I_WR_DATA[7:0];
        OFS_METERING_IRQ_ENABLE_UPPER: next_metering_irq_enable_upper = I_WR_DATA[7:0];
        OFS_ACTIVE_POWER_GAIN: next_active_power_gain = I_WR_DATA[11:0];
        OFS_CURRENT_RMS_OFFSET: next_current_rms_offset = I_WR_DATA[11:0];
        OFS_VOLTAGE_RMS_OFFSET: next_voltage_rms_offset = I_WR_DATA[11:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      second_mode_config <= RST_SECOND_MODE_CONFIG;
      waveform_source_select <= RST_WAVEFORM_SOURCE_SELECT;
      metering_irq_enable_upper <= RST_METERING_IRQ_ENABLE_UPPER;
      active_power_gain <= RST_ACTIVE_POWER_GAIN;
      current_rms_offset <= RST_CURRENT_RMS_OFFSET;
      voltage_rms_offset <= RST_VOLTAGE_RMS_OFFSET;
    end
    else
    begin
      second_mode_config <= next_second_mode_config;
      waveform_source_select <= next_waveform_source_select;
      metering_irq_enable_upper <= next_metering_irq_enable_upper;
      active_power_gain <= next_active_power_gain;
      current_rms_offset <= next_current_rms_offset;
      voltage_rms_offset <= next_voltage_rms_offset;
    end
  end

  // ********************************************
  // filters
  // ********************************************
  logic signed [SQ_W-1:0] cur_sq;
  logic signed [SQ_W-1:0] mean_sq;
  logic signed [VM_W-1:0] volt_abs;
  logic signed [VM_W-1:0] volt_mav;
  logic signed [PW-1:0] inst_power;
  logic signed [PW-1:0] dc_power;

  always_comb
  begin
    cur_sq = I_CUR_SAMPLE * I_CUR_SAMPLE;
    volt_abs = I_VOLT_SAMPLE[VOLT_W-1] ? -{1'b1, I_VOLT_SAMPLE} : {1'b0, I_VOLT_SAMPLE};
    inst_power = I_CUR_SAMPLE * I_VOLT_SAMPLE;
  end

  // squared current average, about 49 Hz corner at the update rate
  rap_lpf #(.W(SQ_W), .K(SQ_AVG_SHIFT)) u_square_average_filter (
    .i_mclk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_en(ce),
    .i_x(cur_sq),
    .o_y(mean_sq)
  );

  rap_lpf #(.W(VM_W), .K(VMAV_SHIFT)) u_voltage_mav_filter (
    .i_mclk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_en(ce),
    .i_x(volt_abs),
    .o_y(volt_mav)
  );

  // first order only: twice-line ripple passes through
  rap_lpf #(.W(PW), .K(PWR_SHIFT)) u_power_dc_filter (
    .i_mclk(I_MCLK),
    .i_rst_b(I_RST_B),
    .i_en(ce),
    .i_x(inst_power),
    .o_y(dc_power)
  );

  // ********************************************
  // current rms square root
  // ********************************************
  logic signed [SQ_W:0] rad_sum;
  logic [49:0] rad_load;
  rap_sqrt_e sq_state;
  rap_sqrt_e next_sq_state;
  logic [49:0] rad_sh;
  logic [49:0] next_rad_sh;
  logic [26:0] rem;
  logic [26:0] next_rem;
  logic [24:0] root_q;
  logic [24:0] next_root_q;
  logic [24:0] root_done;
  logic [24:0] next_root_done;
  logic [4:0] sq_cnt;
  logic [4:0] next_sq_cnt;
  logic [28:0] rem_t;
  logic [28:0] trial;

  always_comb
  begin
    rad_sum = {mean_sq[SQ_W-1], mean_sq}
      + ((SQ_W+1)'(signed'(current_rms_offset)) <<< IRMS_OS_SHIFT);
    rad_load = 50'h0;
    if (!rad_sum[SQ_W])
    begin
      // radicand times four: root carries one extra low bit
      rad_load = {rad_sum[SQ_W-1:0], 2'b00};
    end
    rem_t = {rem, rad_sh[49:48]};
    trial = {2'b00, root_q, 2'b01};
    next_sq_state = sq_state;
    next_rad_sh = rad_sh;
    next_rem = rem;
    next_root_q = root_q;
    next_root_done = root_done;
    next_sq_cnt = sq_cnt;
    unique case (sq_state)
      SQ_IDLE:
      begin
        next_rad_sh = rad_load;
        next_rem = 27'h0;
        next_root_q = 25'h0;
        next_sq_cnt = 5'h0;
        next_sq_state = SQ_RUN;
      end
      SQ_RUN:
      begin
        next_rad_sh = {rad_sh[47:0], 2'b00};
        if (rem_t >= trial)
        begin
          next_rem = rem_t[26:0] - trial[26:0];
          next_root_q = {root_q[23:0], 1'b1};
        end
        else
        begin
          next_rem = rem_t[26:0];
          next_root_q = {root_q[23:0], 1'b0};
        end
        next_sq_cnt = sq_cnt + 5'h1;
        if (sq_cnt == SQRT_LAST)
        begin
          next_root_done = next_root_q;
          next_sq_state = SQ_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      sq_state <= SQ_IDLE;
      rad_sh <= 50'h0;
      rem <= 27'h0;
      root_q <= 25'h0;
      root_done <= 25'h0;
      sq_cnt <= 5'h0;
    end
    else
    begin
      sq_state <= next_sq_state;
      rad_sh <= next_rad_sh;
      rem <= next_rem;
      root_q <= next_root_q;
      root_done <= next_root_done;
      sq_cnt <= next_sq_cnt;
    end
  end

  // ********************************************
  // voltage rms and active power
  // ********************************************
  logic signed [27:0] vrms_sum;
  logic [23:0] vrms_calc;
  logic signed [GF_W-1:0] gain_factor;
  logic signed [PW+GF_W-1:0] power_scaled;
  logic signed [23:0] power_word;

  always_comb
  begin
    // scale maps a full-scale mean absolute value onto the current rms range
    vrms_sum = 28'(volt_mav * signed'({1'b0, VRMS_SCALE}))
      + (28'(signed'(voltage_rms_offset)) <<< VRMS_OS_SHIFT);
    if (vrms_sum < 0)
    begin
      vrms_calc = 24'h0;
    end
    else if (vrms_sum[27:24] != 4'h0)
    begin
      vrms_calc = 24'hffffff;
    end
    else
    begin
      vrms_calc = vrms_sum[23:0];
    end
    gain_factor = GF_W'(signed'(active_power_gain)) + (GF_W'(1) <<< GAIN_FRAC);
    power_scaled = dc_power * gain_factor;
    power_word = power_scaled[PW+GAIN_FRAC-1:PW+GAIN_FRAC-24];
  end

  // ********************************************
  // result registers
  // ********************************************
  logic rms_update;
  logic [23:0] current_rms;
  logic [23:0] voltage_rms;
  logic [23:0] next_current_rms;
  logic [23:0] next_voltage_rms;
  logic signed [23:0] next_active_power;

  always_comb
  begin
    rms_update = second_mode_config[RMS_ZERO_CROSS_UPDATE_BIT] ? I_VOLT_ZX : ce;
    next_current_rms = current_rms;
    next_voltage_rms = voltage_rms;
    next_active_power = O_ACTIVE_POWER;
    if (rms_update)
    begin
      next_current_rms = root_done[24:1];
      next_voltage_rms = vrms_calc;
    end
    if (ce)
    begin
      next_active_power = power_word;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      current_rms <= 24'h0;
      voltage_rms <= 24'h0;
      O_ACTIVE_POWER <= 24'sh0;
    end
    else
    begin
      current_rms <= next_current_rms;
      voltage_rms <= next_voltage_rms;
      O_ACTIVE_POWER <= next_active_power;
    end
  end

  // ********************************************
  // waveform sampling
  // ********************************************
  logic [7:0] wave_cnt;
  logic [7:0] next_wave_cnt;
  logic [7:0] wave_last;
  logic [23:0] wave_pick;
  logic [23:0] next_wave_data;
  logic next_wave_stb;

  always_comb
  begin
    wave_last = 8'((32'(WAVE_BASE_LAST) + 32'h1)
      << waveform_source_select[WAVE_RATE_LSB +: WAVE_RATE_W]) - 8'h1;
    unique case (waveform_source_select[WAVE_SRC_LSB +: WAVE_SRC_W])
      WAVE_SRC_CURRENT: wave_pick = 24'(I_CUR_SAMPLE);
      WAVE_SRC_VOLTAGE: wave_pick = 24'(I_VOLT_SAMPLE);
      WAVE_SRC_POWER: wave_pick = O_ACTIVE_POWER;
      WAVE_SRC_CURRENT_RMS: wave_pick = root_done[23:0];
      default: wave_pick = 24'h0;
    endcase
    next_wave_cnt = wave_cnt;
    next_wave_data = O_WAVE_DATA;
    next_wave_stb = 1'b0;
    if (ce)
    begin
      next_wave_cnt = wave_cnt + 8'h1;
      if (wave_cnt >= wave_last)
      begin
        next_wave_cnt = 8'h0;
        if (metering_irq_enable_upper[WAVEFORM_SAMPLE_IRQ_ENABLE_BIT])
        begin
          next_wave_data = wave_pick;
          next_wave_stb = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      wave_cnt <= 8'h0;
      O_WAVE_DATA <= 24'h0;
      O_WAVE_STB <= 1'b0;
    end
    else
    begin
      wave_cnt <= next_wave_cnt;
      O_WAVE_DATA <= next_wave_data;
      O_WAVE_STB <= next_wave_stb;
    end
  end

  // ********************************************
  // register read
  // ********************************************
  logic [DATA_W-1:0] next_rd_data;

  always_comb
  begin
    next_rd_data = '0;
    if (I_RD_STB)
    begin
      unique case (I_ADDR)
        OFS_SECOND_MODE_CONFIG: next_rd_data = {8'h00, second_mode_config};
        OFS_WAVEFORM_SOURCE_SELECT: next_rd_data = {8'h00, waveform_source_select};
        OFS_METERING_IRQ_ENABLE_UPPER: next_rd_data = {8'h00, metering_irq_enable_upper};
        OFS_ACTIVE_POWER_GAIN: next_rd_data = {4'h0, active_power_gain};
        OFS_CURRENT_RMS_OFFSET: next_rd_data = {4'h0, current_rms_offset};
        OFS_VOLTAGE_RMS_OFFSET: next_rd_data = {4'h0, voltage_rms_offset};
        OFS_VOLTAGE_RMS_LOW_BYTE: next_rd_data = {8'h00, voltage_rms[7:0]};
        OFS_VOLTAGE_RMS_MID_BYTE: next_rd_data = {8'h00, voltage_rms[15:8]};
        OFS_VOLTAGE_RMS_HIGH_BYTE: next_rd_data = {8'h00, voltage_rms[23:16]};
        OFS_CURRENT_RMS_LOW_BYTE: next_rd_data = {8'h00, current_rms[7:0]};
        OFS_CURRENT_RMS_MID_BYTE: next_rd_data = {8'h00, current_rms[15:8]};
        OFS_CURRENT_RMS_HIGH_BYTE: next_rd_data = {8'h00, current_rms[23:16]};
        default: next_rd_data = '0;
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      O_RD_DATA <= '0;
    end
    else
    begin
      O_RD_DATA <= next_rd_data;
    end
  end

endmodule

// ===== dv/rap_adc_model.sv
// square-wave stand-in for the adc filter chain feeding the block
// assumes the bench sets amplitudes; zero-cross pulse at each sign flip
`timescale 1ns/1ps
module rap_adc_model #(
  parameter int HALF = 200
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [23:0] i_cur_amp,
  input wire logic [15:0] i_volt_amp,
  output logic signed [23:0] o_cur,
  output logic signed [15:0] o_volt,
  output logic o_zx
);
  // ********
  // waveform
  // ********
  int cnt;
  logic pos;
  // current and voltage in phase, so the product is a steady dc
  assign o_cur = pos ? i_cur_amp : -i_cur_amp;
  assign o_volt = pos ? i_volt_amp : -i_volt_amp;
  always_ff @(posedge i_mclk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt <= 0;
      pos <= 1'b1;
      o_zx <= 1'b0;
    end
    else
    begin
      o_zx <= (cnt == HALF - 1);
      pos <= (cnt == HALF - 1) ? ~pos : pos;
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    end
  end
endmodule

// ===== dv/rap_checker.sv
// port-level checks for the rms and active power block
// assumes it is bound to the block's top module
`timescale 1ns/1ps
module rap_checker
  import rap_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_RST_B,
  input wire logic [rap_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [rap_pkg::DATA_W-1:0] I_WR_DATA,
  input wire logic I_WR_STB,
  input wire logic I_RD_STB,
  input wire logic I_VOLT_ZX,
  input wire logic [rap_pkg::DATA_W-1:0] O_RD_DATA,
  input wire logic [23:0] O_WAVE_DATA,
  input wire logic O_WAVE_STB,
  input wire logic signed [23:0] O_ACTIVE_POWER
);
  // ********
  // shadow state
  // ********
  logic [11:0] gain_sh;
  logic [11:0] next_gain_sh;
  logic waveform_sample_irq_enable;
  logic next_waveform_sample_irq_enable;
  logic [11:0] gap;
  logic [11:0] next_gap;
  always_comb
  begin
    next_gain_sh = gain_sh;
    next_waveform_sample_irq_enable = waveform_sample_irq_enable;
    next_gap = (gap == 12'hfff) ? gap : gap + 12'h001;
    if (I_WR_STB && I_ADDR == OFS_ACTIVE_POWER_GAIN)
      next_gain_sh = I_WR_DATA[11:0];
    if (I_WR_STB && I_ADDR == OFS_METERING_IRQ_ENABLE_UPPER)
      next_waveform_sample_irq_enable = I_WR_DATA[WAVEFORM_SAMPLE_IRQ_ENABLE_BIT];
    if (O_WAVE_STB)
      next_gap = 12'h000;
  end
  always_ff @(posedge I_MCLK or negedge I_RST_B)
  begin
    if (!I_RST_B)
    begin
      gain_sh <= 12'h000;
      waveform_sample_irq_enable <= 1'b0;
      gap <= 12'hfff;
    end
    else
    begin
      gain_sh <= next_gain_sh;
      waveform_sample_irq_enable <= next_waveform_sample_irq_enable;
      gap <= next_gap;
    end
  end
  // ********
  // properties
  // ********
  default clocking cb @(posedge I_MCLK);
  endclocking
  default disable iff (!I_RST_B);
  rd_idle_a: assert property (!I_RD_STB |=> O_RD_DATA == 16'h0000)
    else $error("read data outside read cycle");
  rms_byte_a: assert property (I_RD_STB && I_ADDR inside {[8'hd1:8'hd6]} |=> O_RD_DATA[15:8] == 8'h00)
    else $error("rms byte read wider than 8 bits");
  gain_read_a: assert property (I_RD_STB && I_ADDR == OFS_ACTIVE_POWER_GAIN |=> O_RD_DATA == {4'h0, gain_sh})
    else $error("gain readback differs from last write");
  wave_pulse_a: assert property (O_WAVE_STB |=> !O_WAVE_STB)
    else $error("wave strobe longer than one cycle");
  wave_gap_a: assert property (O_WAVE_STB |-> gap >= 12'h09f)
    else $error("wave strobes too close");
  wave_enable_a: assert property (O_WAVE_STB |-> waveform_sample_irq_enable || $past(waveform_sample_irq_enable))
    else $error("wave strobe while sampling disabled");
  wave_data_a: assert property ($changed(O_WAVE_DATA) |-> O_WAVE_STB)
    else $error("wave data moved without strobe");
  power_rate_a: assert property ($changed(O_ACTIVE_POWER) |=> $stable(O_ACTIVE_POWER) [*4])
    else $error("power refreshed faster than clock/5");
  cover property (O_WAVE_STB);
  cover property (I_RD_STB && I_ADDR == OFS_CURRENT_RMS_LOW_BYTE);
  cover property (I_VOLT_ZX);
endmodule
bind rms_and_active_power_dsp rap_checker i_chk (.I_MCLK(I_MCLK), .I_RST_B(I_RST_B), .I_ADDR(I_ADDR),
  .I_WR_DATA(I_WR_DATA), .I_WR_STB(I_WR_STB), .I_RD_STB(I_RD_STB), .I_VOLT_ZX(I_VOLT_ZX),
  .O_RD_DATA(O_RD_DATA), .O_WAVE_DATA(O_WAVE_DATA), .O_WAVE_STB(O_WAVE_STB), .O_ACTIVE_POWER(O_ACTIVE_POWER));

// ===== dv/rms_and_active_power_dsp_test.sv
// register-level tests of the rms and active power block
// assumes the adc stand-in and the bound checker
`timescale 1ns/1ps
module rms_and_active_power_dsp_test;
  import rap_pkg::*;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdat = 16'h0000;
  logic wstb = 1'b0;
  logic rstb = 1'b0;
  logic [23:0] cur_amp = 24'h000000;
  logic [15:0] volt_amp = 16'h0000;
  logic signed [23:0] cur;
  logic signed [15:0] volt;
  logic zx;
  logic [15:0] rdat;
  logic [23:0] wave;
  logic wave_stb;
  logic signed [23:0] pwr;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  logic [15:0] d;
  logic [23:0] v;
  logic [23:0] v1;
  longint p0;
  longint p1;
  logic [7:0] rst_list [7] = '{8'h0c, 8'h0d, 8'h1d, 8'h22, 8'h23, 8'hdb, 8'h50};
  logic [11:0] os_tab [4] = '{12'h7ff, 12'h001, 12'h800, 12'h123};
  always #5 mclk = ~mclk;
  rap_adc_model i_adc (.i_mclk(mclk), .i_rst_b(rst_b), .i_cur_amp(cur_amp), .i_volt_amp(volt_amp),
    .o_cur(cur), .o_volt(volt), .o_zx(zx));
  rms_and_active_power_dsp i_dut (.I_MCLK(mclk), .I_RST_B(rst_b), .I_ADDR(addr), .I_WR_DATA(wdat),
    .I_WR_STB(wstb), .I_RD_STB(rstb), .I_CUR_SAMPLE(cur), .I_VOLT_SAMPLE(volt), .I_VOLT_ZX(zx),
    .O_RD_DATA(rdat), .O_WAVE_DATA(wave), .O_WAVE_STB(wave_stb), .O_ACTIVE_POWER(pwr));
  // ********
  // helpers
  // ********
  function automatic logic [23:0] cur_exp(input logic [11:0] os, input logic raw);
    longint x;
    longint r;
    x = longint'($signed(os)) * 32768 * 4;
    r = 0;
    while ((r + 1) * (r + 1) <= x)
      r++;
    return raw ? 24'(r) : 24'(r >> 1);
  endfunction
  function automatic logic [23:0] volt_exp(input logic [11:0] os);
    longint x;
    x = longint'($signed(os)) * 64;
    return (x < 0) ? 24'h000000 : 24'(x);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] dt);
    addr <= a;
    wdat <= dt;
    wstb <= 1'b1;
    @(posedge mclk);
    wstb <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] dt);
    addr <= a;
    rstb <= 1'b1;
    @(posedge mclk);
    rstb <= 1'b0;
    @(posedge mclk);
    dt = rdat;
  endtask
  task automatic rd24(input logic [7:0] a, output logic [23:0] r);
    logic [15:0] b;
    for (int i = 0; i < 3; i++)
    begin
      rd(a + 8'(i), b);
      r[8*i +: 8] = b[7:0];
    end
  endtask
  task automatic wait_stb(input int limit);
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wave_stb !== 1'b1 && n < limit);
  endtask
  task automatic wait_zx();
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (zx !== 1'b1 && n < 400);
    chk(zx, 1'b1);
  endtask
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    #800000;
    error_cnt++;
    final_report();
  end
  // ********
  // tests
  // ********
  initial
  begin
    repeat (5) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    foreach (rst_list[i])
    begin
      rd(rst_list[i], d);
      chk(d, 16'h0000);
    end
    wr(OFS_ACTIVE_POWER_GAIN, 16'hf123);
    rd(OFS_ACTIVE_POWER_GAIN, d);
    chk(d, 16'h0123);
    wr(OFS_CURRENT_RMS_LOW_BYTE, 16'h00ff);
    rd24(OFS_CURRENT_RMS_LOW_BYTE, v);
    chk(v, 24'h000000);
    $display("test registers done");
    foreach (os_tab[i])
    begin
      wr(OFS_CURRENT_RMS_OFFSET, {4'h0, os_tab[i]});
      wr(OFS_VOLTAGE_RMS_OFFSET, {4'h0, os_tab[i]});
      repeat (80) @(posedge mclk);
      rd24(OFS_CURRENT_RMS_LOW_BYTE, v);
      chk(v, cur_exp(os_tab[i], 1'b0));
      rd24(OFS_VOLTAGE_RMS_LOW_BYTE, v);
      chk(v, volt_exp(os_tab[i]));
    end
    $display("test offsets done");
    wr(OFS_SECOND_MODE_CONFIG, 16'h0004);
    wait_zx();
    wr(OFS_CURRENT_RMS_OFFSET, 16'h0001);
    wr(OFS_VOLTAGE_RMS_OFFSET, 16'h0001);
    repeat (60) @(posedge mclk);
    rd24(OFS_CURRENT_RMS_LOW_BYTE, v);
    chk(v, cur_exp(12'h123, 1'b0));
    rd24(OFS_VOLTAGE_RMS_LOW_BYTE, v);
    chk(v, volt_exp(12'h123));
    wait_zx();
    repeat (3) @(posedge mclk);
    rd24(OFS_CURRENT_RMS_LOW_BYTE, v);
    chk(v, cur_exp(12'h001, 1'b0));
    rd24(OFS_VOLTAGE_RMS_LOW_BYTE, v);
    chk(v, volt_exp(12'h001));
    wr(OFS_SECOND_MODE_CONFIG, 16'h0000);
    $display("test zero cross done");
    wr(OFS_METERING_IRQ_ENABLE_UPPER, 16'h0020);
    for (int s = 0; s < 5; s++)
    begin
      wr(OFS_WAVEFORM_SOURCE_SELECT, 16'(s));
      wait_stb(400);
      chk(wave_stb, 1'b1);
      wait_stb(400);
      chk(n, 160);
      chk(wave, (s == 3) ? cur_exp(12'h001, 1'b1) : 24'h000000);
    end
    for (int r = 1; r < 4; r++)
    begin
      wr(OFS_WAVEFORM_SOURCE_SELECT, 16'((r << 3) | 3));
      wait_stb(2000);
      chk(wave_stb, 1'b1);
      wait_stb(2000);
      chk(n, 160 << r);
    end
    wr(OFS_METERING_IRQ_ENABLE_UPPER, 16'h0000);
    wait_stb(2000);
    chk(n, 2000);
    $display("test waveform done");
    wr(OFS_ACTIVE_POWER_GAIN, 16'h0000);
    cur_amp <= 24'h400000;
    volt_amp <= 16'h4000;
    repeat (20000) @(posedge mclk);
    rd24(OFS_VOLTAGE_RMS_LOW_BYTE, v1);
    repeat (2000) @(posedge mclk);
    rd24(OFS_VOLTAGE_RMS_LOW_BYTE, v);
    chk(v > v1, 1);
    p0 = longint'(pwr);
    chk(p0 > 0, 1);
    wr(OFS_ACTIVE_POWER_GAIN, 16'h0800);
    repeat (10) @(posedge mclk);
    p1 = 2 * longint'(pwr) - p0;
    chk(((p1 < 0) ? -p1 : p1) * 200 < p0, 1);
    wr(OFS_ACTIVE_POWER_GAIN, 16'h07ff);
    repeat (10) @(posedge mclk);
    p1 = 4096 * longint'(pwr) - 6143 * p0;
    chk(((p1 < 0) ? -p1 : p1) * 200 < 6143 * p0, 1);
    // live samples: source decode must pick the right channel
    wr(OFS_METERING_IRQ_ENABLE_UPPER, 16'h0020);
    for (int s = 0; s < 2; s++)
    begin
      wr(OFS_WAVEFORM_SOURCE_SELECT, 16'(s));
      wait_stb(2000);
      wait_stb(400);
      chk(wave == (s ? 24'h004000 : 24'h400000) || wave == (s ? 24'hffc000 : 24'hc00000), 1);
    end
    $display("test power done");
    final_report();
  end
endmodule
